// *** src/fec_pkg.sv ***
// Purpose: Constants and types for the function enable condition selector
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: Selection codes are paired; bit 0 of a code inverts the condition
package fec_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CW_SEL = 8'h00;
  localparam logic [7:0] ADDR_CCW_SEL = 8'h04;
  localparam logic [7:0] ADDR_ACTION = 8'h08;
  localparam logic [7:0] ADDR_SEQ_TORQUE = 8'h0C;
  localparam logic [7:0] ADDR_PEAK_TORQUE = 8'h10;
  localparam logic [7:0] ADDR_LOW_SPEED = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_FUNC_BASE = 8'h40;

  // Number of general functions with their own selection code
  localparam int NUM_FUNC = 8;

  // Reset values
  localparam logic [5:0] RST_CW_SEL = 6'h0D;
  localparam logic [5:0] RST_CCW_SEL = 6'h0B;
  localparam logic [5:0] RST_FUNC_SEL = 6'h00;
  localparam logic [2:0] RST_ACTION = 3'h0;
  localparam logic [15:0] RST_TORQUE = 16'hFFFF;
  localparam logic [15:0] RST_LOW_SPEED = 16'h0000;

  // Selection code pairs, code divided by two
  localparam logic [4:0] PAIR_CONST = 5'h00;
  localparam logic [4:0] PAIR_GIN_FIRST = 5'h01;
  localparam logic [4:0] PAIR_GIN_LAST = 5'h08;
  localparam logic [4:0] PAIR_LOW_SPEED = 5'h09;
  localparam logic [4:0] PAIR_ATTAIN = 5'h0A;
  localparam logic [4:0] PAIR_MATCH = 5'h0B;
  localparam logic [4:0] PAIR_ZERO = 5'h0C;
  localparam logic [4:0] PAIR_INPOS = 5'h0D;
  localparam logic [4:0] PAIR_TORQUE_LIM = 5'h0E;
  localparam logic [4:0] PAIR_VEL_LIM = 5'h0F;
  localparam logic [4:0] PAIR_NEAR = 5'h10;
  localparam logic [4:0] PAIR_CW_DIR = 5'h11;
  localparam logic [4:0] PAIR_CCW_DIR = 5'h12;
  localparam logic [4:0] PAIR_INPZ = 5'h13;

  // Over-travel stop actions
  localparam logic [2:0] ACT_SB_ON = 3'h0;
  localparam logic [2:0] ACT_DB_ON = 3'h1;
  localparam logic [2:0] ACT_FREE_ON = 3'h2;
  localparam logic [2:0] ACT_SB_OFF = 3'h3;
  localparam logic [2:0] ACT_DB_OFF = 3'h4;
  localparam logic [2:0] ACT_FREE_OFF = 3'h5;
  localparam logic [2:0] ACT_ACCEPT = 3'h6;

  // Over-travel sequence states
  typedef enum logic [1:0] {
    OT_IDLE,
    OT_STOP,
    OT_HOLD
  } fec_ot_state_t;

endpackage

// *** src/fec_condition_select.sv ***
// Purpose: Function enable condition selector with over-travel stop logic
// Assumes: Status inputs come from logic on i_clk; generic inputs are pins
// Notes: All outputs are registered; i_ce low freezes every flip-flop
//
// Overview of operation
// - Code 00 never valid, 01 always valid
// - Codes 02..11 follow generic inputs, odd inverted
// - Codes 12/13 low-speed status or its absence
// - Codes 14/15 speed attainment or its absence
// - Codes 16/17 speed match or mismatch
// - Codes 18/19 zero-speed status or its absence
// - Codes 20/21 near-target status or absence
// - Codes 1A/1B in-position status or absence
// - Code 26 zero command and in-position
// - Codes 1C/1D torque-limit status or not
// - Codes 1E/1F velocity-limit status or not
// - Codes 22/23 monitor above plus low speed
// - Codes 24/25 monitor below minus low speed
// - Travel limits on any generic input stop motion
// - Action 00 inhibits, servo-brakes, keeps servo on
// - Action 01 inhibits, dynamic-brakes, servo on after
// - Coast stay-on action coasts, servo on after
// - Action 03 inhibits, servo-brakes, servo off after
// - Dynamic-brake off action, servo off after stop
// - Coast off action coasts, servo off after
// - Action 06 accepts commands, zeroes tripped limit
// - Servo-brake torque is sequence limit clamped peak
`timescale 1ns/1ps

module fec_condition_select #(
  parameter int VW = 16,
  parameter int TW = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [7:0] i_generic_in,
  input wire logic i_low_speed,
  input wire logic i_speed_attain,
  input wire logic i_speed_match,
  input wire logic i_zero_speed,
  input wire logic i_near,
  input wire logic i_in_position,
  input wire logic i_pos_cmd_zero,
  input wire logic i_torque_limited,
  input wire logic i_velocity_limited,
  input wire logic signed [VW-1:0] i_velocity_monitor,
  input wire logic i_motor_stopped,
  output logic [fec_pkg::NUM_FUNC-1:0] o_func_valid,
  output logic o_cw_travel_limit,
  output logic o_ccw_travel_limit,
  output logic o_cmd_inhibit,
  output logic o_cw_vel_limit_zero,
  output logic o_ccw_vel_limit_zero,
  output logic o_servo_brake,
  output logic o_dyn_brake,
  output logic o_coast,
  output logic o_servo_enable,
  output logic [TW-1:0] o_torque_limit
);

  // Status bundle bit positions used by the selector function
  localparam int S_LOW = 0;
  localparam int S_ATT = 1;
  localparam int S_MATCH = 2;
  localparam int S_ZERO = 3;
  localparam int S_INPOS = 4;
  localparam int S_TLC = 5;
  localparam int S_VLC = 6;
  localparam int S_NEAR = 7;
  localparam int S_CW = 8;
  localparam int S_CCW = 9;
  localparam int S_INPZ = 10;

  // Evaluate one selection code against inputs and status
  function automatic logic sel_valid(input logic [5:0] code,
                                     input logic [7:0] gin,
                                     input logic [10:0] st);
    logic base;
    logic hit;
    logic [3:0] gi;
    base = 1'b0;
    hit = 1'b1;
    gi = code[4:1] - 4'h1;
    if (code[5:1] >= fec_pkg::PAIR_GIN_FIRST &&
        code[5:1] <= fec_pkg::PAIR_GIN_LAST) begin
      base = gin[gi[2:0]];
    end else begin
      case (code[5:1])
        // constant pair, even never, odd always
        fec_pkg::PAIR_CONST: base = 1'b0;
        fec_pkg::PAIR_LOW_SPEED: base = st[S_LOW];
        fec_pkg::PAIR_ATTAIN: base = st[S_ATT];
        fec_pkg::PAIR_MATCH: base = st[S_MATCH];
        fec_pkg::PAIR_ZERO: base = st[S_ZERO];
        fec_pkg::PAIR_INPOS: base = st[S_INPOS];
        fec_pkg::PAIR_TORQUE_LIM: base = st[S_TLC];
        fec_pkg::PAIR_VEL_LIM: base = st[S_VLC];
        fec_pkg::PAIR_NEAR: base = st[S_NEAR];
        fec_pkg::PAIR_CW_DIR: base = st[S_CW];
        fec_pkg::PAIR_CCW_DIR: base = st[S_CCW];
        fec_pkg::PAIR_INPZ: base = st[S_INPZ];
        default: hit = 1'b0;
      endcase
    end
    sel_valid = hit & (base ^ code[0]);
  endfunction

  // Configuration registers
  logic [5:0] cw_sel;
  logic [5:0] ccw_sel;
  logic [2:0] action;
  logic [TW-1:0] seq_torque;
  logic [TW-1:0] peak_torque;
  logic [VW-1:0] low_speed_setting;
  logic [5:0] func_sel [fec_pkg::NUM_FUNC];
  // Generic input synchroniser stages
  logic [7:0] gin_meta;
  logic [7:0] gin_sync;
  logic [1:0] gin_fill; // Ones shift in as real pin samples arrive
  // Over-travel sequence state
  fec_pkg::fec_ot_state_t ot_state;
  fec_pkg::fec_ot_state_t next_ot_state;
  // Decoded strobes and addressing
  wire wr_cw = i_wr && (i_addr == fec_pkg::ADDR_CW_SEL);
  wire wr_ccw = i_wr && (i_addr == fec_pkg::ADDR_CCW_SEL);
  wire wr_action = i_wr && (i_addr == fec_pkg::ADDR_ACTION);
  wire wr_seq = i_wr && (i_addr == fec_pkg::ADDR_SEQ_TORQUE);
  wire wr_peak = i_wr && (i_addr == fec_pkg::ADDR_PEAK_TORQUE);
  wire wr_low = i_wr && (i_addr == fec_pkg::ADDR_LOW_SPEED);
  // Function slots occupy a word each above the base
  wire [7:0] func_off = i_addr - fec_pkg::ADDR_FUNC_BASE;
  wire func_hit = (i_addr >= fec_pkg::ADDR_FUNC_BASE) &&
                  (func_off[7:2] < 6'(fec_pkg::NUM_FUNC)) &&
                  (func_off[1:0] == 2'h0);
  wire [2:0] func_idx = func_off[4:2];
  // Direction status from the signed velocity monitor
  wire signed [VW-1:0] low_pos = low_speed_setting;
  wire signed [VW-1:0] low_neg = -low_speed_setting;
  wire dir_cw = i_velocity_monitor > low_pos;
  wire dir_ccw = i_velocity_monitor < low_neg;
  // Status bundle handed to the selector
  wire [10:0] status_vec = {i_pos_cmd_zero & i_in_position, dir_ccw, dir_cw,
                            i_near, i_velocity_limited, i_torque_limited,
                            i_in_position, i_zero_speed, i_speed_match,
                            i_speed_attain, i_low_speed};

  // travel limits take any generic input via their codes
  // Reset zeros in the stages are not pin levels, so no trip yet
  wire cw_trip = gin_fill[1] & sel_valid(cw_sel, gin_sync, status_vec);
  wire ccw_trip = gin_fill[1] & sel_valid(ccw_sel, gin_sync, status_vec);
  wire any_trip = cw_trip | ccw_trip;

  // Selector results for the general functions
  logic [fec_pkg::NUM_FUNC-1:0] next_func_valid;
  always_comb begin
    for (int i = 0; i < fec_pkg::NUM_FUNC; i++) begin
      next_func_valid[i] = sel_valid(func_sel[i], gin_sync, status_vec);
    end
  end

  // Action decode; unknown values behave as the first action
  wire act_accept = (action == fec_pkg::ACT_ACCEPT);
  wire act_sb = (action == fec_pkg::ACT_SB_OFF) ||
                (action == fec_pkg::ACT_SB_ON) ||
                (action > fec_pkg::ACT_ACCEPT);
  wire act_db = (action == fec_pkg::ACT_DB_ON) ||
                (action == fec_pkg::ACT_DB_OFF);
  wire act_free = (action == fec_pkg::ACT_FREE_ON) ||
                  (action == fec_pkg::ACT_FREE_OFF);
  wire act_stay_on = (action <= fec_pkg::ACT_FREE_ON) ||
                     (action > fec_pkg::ACT_ACCEPT);

  // Next state of the over-travel stop sequence
  always_comb begin
    next_ot_state = ot_state;
    case (ot_state)
      fec_pkg::OT_IDLE: begin
        // accept action never enters the stop sequence
        if (any_trip && !act_accept) begin
          next_ot_state = fec_pkg::OT_STOP;
        end
      end
      fec_pkg::OT_STOP: begin
        // Braking or coasting ends when the motor is at rest
        if (i_motor_stopped) begin
          next_ot_state = fec_pkg::OT_HOLD;
        end
      end
      fec_pkg::OT_HOLD: begin
        // Leave only once the limit is released
        if (!any_trip) begin
          next_ot_state = fec_pkg::OT_IDLE;
        end
      end
      default: next_ot_state = fec_pkg::OT_IDLE;
    endcase
  end

  // Output decode from the current sequence state and the trip flags
  wire stopping = (ot_state == fec_pkg::OT_STOP);
  wire holding = (ot_state == fec_pkg::OT_HOLD);
  // commands inhibited while the sequence runs
  wire next_inhibit = stopping | holding;
  // tripped direction velocity limit forced to zero
  wire next_cw_zero = cw_trip;
  wire next_ccw_zero = ccw_trip;
  wire next_sb = stopping & act_sb;
  wire next_db = stopping & act_db;
  wire next_coast = stopping & act_free;
  // Servo-brake needs the servo energized; other stops drop it
  logic next_servo;
  always_comb begin
    next_servo = 1'b1;
    if (stopping) begin
      // servo stays on during a servo-brake stop
      next_servo = act_sb;
    end else if (holding) begin
      // off-actions leave the servo off after the stop
      next_servo = act_stay_on;
    end
  end
  // servo-brake torque clamped to the motor peak
  wire [TW-1:0] clamp_torque = (seq_torque > peak_torque) ?
                               peak_torque : seq_torque;
  wire [TW-1:0] next_torque = next_sb ? clamp_torque : peak_torque;

  // Status word shown to software
  wire [31:0] status_word = {16'h0000, o_func_valid, 1'b0, o_servo_enable,
                             o_coast, o_dyn_brake, o_servo_brake,
                             o_cmd_inhibit, ccw_trip, cw_trip};

  // Read data multiplexer; unmapped addresses read zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    if (func_hit) begin
      next_rdata = {26'h0000000, func_sel[func_idx]};
    end else begin
      case (i_addr)
        fec_pkg::ADDR_CW_SEL: next_rdata = {26'h0000000, cw_sel};
        fec_pkg::ADDR_CCW_SEL: next_rdata = {26'h0000000, ccw_sel};
        fec_pkg::ADDR_ACTION: next_rdata = {29'h00000000, action};
        fec_pkg::ADDR_SEQ_TORQUE: next_rdata = 32'(seq_torque);
        fec_pkg::ADDR_PEAK_TORQUE: next_rdata = 32'(peak_torque);
        fec_pkg::ADDR_LOW_SPEED: next_rdata = 32'(low_speed_setting);
        fec_pkg::ADDR_STATUS: next_rdata = status_word;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Two-stage synchroniser for the generic input pins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gin_meta <= 8'h00;
      gin_sync <= 8'h00;
      gin_fill <= 2'h0;
    end else if (i_ce) begin
      gin_meta <= i_generic_in;
      gin_sync <= gin_meta;
      gin_fill <= {gin_fill[0], 1'b1};
    end
  end

  // Scalar configuration registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cw_sel <= fec_pkg::RST_CW_SEL;
      ccw_sel <= fec_pkg::RST_CCW_SEL;
      action <= fec_pkg::RST_ACTION;
      seq_torque <= TW'(fec_pkg::RST_TORQUE);
      peak_torque <= TW'(fec_pkg::RST_TORQUE);
      low_speed_setting <= VW'(fec_pkg::RST_LOW_SPEED);
    end else if (i_ce) begin
      if (wr_cw) cw_sel <= i_wdata[5:0];
      if (wr_ccw) ccw_sel <= i_wdata[5:0];
      if (wr_action) action <= i_wdata[2:0];
      if (wr_seq) seq_torque <= i_wdata[TW-1:0];
      if (wr_peak) peak_torque <= i_wdata[TW-1:0];
      if (wr_low) low_speed_setting <= i_wdata[VW-1:0];
    end
  end

  // Per-function selection codes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < fec_pkg::NUM_FUNC; i++) begin
        func_sel[i] <= fec_pkg::RST_FUNC_SEL;
      end
    end else if (i_ce && i_wr && func_hit) begin
      func_sel[func_idx] <= i_wdata[5:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? next_rdata : 32'h00000000;
    end
  end

  // Sequence state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ot_state <= fec_pkg::OT_IDLE;
    end else if (i_ce) begin
      ot_state <= next_ot_state;
    end
  end

  // Registered drive outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_func_valid <= '0;
      o_cw_travel_limit <= 1'b0;
      o_ccw_travel_limit <= 1'b0;
      o_cmd_inhibit <= 1'b0;
      o_cw_vel_limit_zero <= 1'b0;
      o_ccw_vel_limit_zero <= 1'b0;
      o_servo_brake <= 1'b0;
      o_dyn_brake <= 1'b0;
      o_coast <= 1'b0;
      o_servo_enable <= 1'b1;
      o_torque_limit <= TW'(fec_pkg::RST_TORQUE);
    end else if (i_ce) begin
      o_func_valid <= next_func_valid;
      o_cw_travel_limit <= cw_trip;
      o_ccw_travel_limit <= ccw_trip;
      o_cmd_inhibit <= next_inhibit;
      o_cw_vel_limit_zero <= next_cw_zero;
      o_ccw_vel_limit_zero <= next_ccw_zero;
      o_servo_brake <= next_sb;
      o_dyn_brake <= next_db;
      o_coast <= next_coast;
      o_servo_enable <= next_servo;
      o_torque_limit <= next_torque;
    end
  end
endmodule

// *** tb/fec_condition_select_sva.sv ***
// Purpose: Port checker for the condition selector
// Assumes: One clock, asynchronous active-low reset
// Notes: Stop action is shadowed from register writes
`timescale 1ns/1ps
module fec_sva #(
  parameter int VW = 16,
  parameter int TW = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [fec_pkg::NUM_FUNC-1:0] o_func_valid,
  input wire logic o_cw_travel_limit,
  input wire logic o_cmd_inhibit,
  input wire logic o_cw_vel_limit_zero,
  input wire logic o_servo_brake,
  input wire logic o_dyn_brake,
  input wire logic o_coast,
  input wire logic o_servo_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [2:0] act_q; // Shadow of the stop action
  logic [1:0] act_age; // Enabled edges since it was last written, saturating at 3
  logic act_wr; // Action register written
  logic fn_wr; // Function 0 code written
  assign act_wr = i_ce && i_wr && i_addr == fec_pkg::ADDR_ACTION;
  assign fn_wr = i_ce && i_wr && i_addr == fec_pkg::ADDR_FUNC_BASE;
  // Age lets a new action settle before it is trusted
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      act_q <= fec_pkg::RST_ACTION;
      act_age <= 2'h0;
    end else if (act_wr) begin
      act_q <= i_wdata[2:0];
      act_age <= 2'h0;
    end else if (i_ce && act_age != 2'h3) begin
      act_age <= act_age + 2'h1;
    end
  end
  property p_code_const;
    fn_wr && i_wdata[5:1] == 5'h00 ##1 i_ce && !i_wr
      |=> o_func_valid[0] == $past(i_wdata[0], 2);
  endproperty
  a_code_const: assert property (p_code_const)
    else $error("constant code gave wrong function valid");
  property p_code_unlisted;
    fn_wr && i_wdata[5:0] > 6'h27 ##1 i_ce && !i_wr |=> !o_func_valid[0];
  endproperty
  a_code_unlisted: assert property (p_code_unlisted)
    else $error("unlisted code made function valid");
  property p_sb_hold_on;
    act_q == fec_pkg::ACT_SB_ON && act_age == 2'h3 && o_cmd_inhibit
      |-> o_servo_enable;
  endproperty
  a_sb_hold_on: assert property (p_sb_hold_on)
    else $error("servo dropped under servo-brake stay-on");
  property p_sb_hold_off;
    act_q == fec_pkg::ACT_SB_OFF && act_age == 2'h3 && o_cmd_inhibit
      && !o_servo_brake |-> !o_servo_enable;
  endproperty
  a_sb_hold_off: assert property (p_sb_hold_off)
    else $error("servo kept on after servo-brake stop");
  property p_sb_stop;
    o_servo_brake |-> o_servo_enable && o_cmd_inhibit && !o_dyn_brake
      && !o_coast;
  endproperty
  a_sb_stop: assert property (p_sb_stop)
    else $error("servo-brake stop without servo or inhibit");
  property p_dyn_stop;
    o_dyn_brake |-> !o_servo_enable && o_cmd_inhibit && !o_coast;
  endproperty
  a_dyn_stop: assert property (p_dyn_stop)
    else $error("dynamic brake with servo on");
  property p_coast_stop;
    o_coast |-> !o_servo_enable && o_cmd_inhibit;
  endproperty
  a_coast_stop: assert property (p_coast_stop)
    else $error("coast with servo on or commands open");
  property p_accept;
    act_q == fec_pkg::ACT_ACCEPT && act_age == 2'h3 && !o_cmd_inhibit
      |=> !o_cmd_inhibit;
  endproperty
  a_accept: assert property (p_accept)
    else $error("commands inhibited under accept action");
  property p_vel_zero;
    $past(i_ce) && $past(o_cw_travel_limit) && o_cw_travel_limit
      |-> o_cw_vel_limit_zero;
  endproperty
  a_vel_zero: assert property (p_vel_zero)
    else $error("tripped direction limit not zeroed");
  property p_status;
    i_ce && i_rd && i_addr == fec_pkg::ADDR_STATUS
      |=> o_rdata[31:8] == {16'h0000, $past(o_func_valid)}
      && o_rdata[6:2] == $past({o_servo_enable, o_coast, o_dyn_brake,
      o_servo_brake, o_cmd_inhibit});
  endproperty
  a_status: assert property (p_status)
    else $error("status read disagrees with outputs");
  c_dyn: cover property (o_dyn_brake);
  c_coast: cover property (o_coast);
  c_accept_trip: cover property (act_q == 3'h6 && o_cw_travel_limit);
endmodule
bind fec_condition_select fec_sva #(.VW(VW), .TW(TW)) fec_sva_inst (
  .i_clk, .i_reset_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_func_valid, .o_cw_travel_limit, .o_cmd_inhibit, .o_cw_vel_limit_zero,
  .o_servo_brake, .o_dyn_brake, .o_coast, .o_servo_enable
);

// *** tb/fec_host_model.sv ***
// Purpose: Host equipment driving the generic input pins
// Assumes: Contacts change just after a clock edge
// Notes: Slow mode adds two cycles of relay lag
`timescale 1ns/1ps
module fec_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_want, // Levels the host asks for
  input wire logic i_slow, // Relay lag on
  output logic [7:0] o_generic_in
);
  logic [7:0] lag1; // First lag stage
  logic [7:0] lag2; // Second lag stage
  always_ff @(posedge i_clk) begin
    lag1 <= i_want;
    lag2 <= lag1;
    o_generic_in <= i_slow ? lag2 : i_want;
  end
endmodule

// *** tb/test_function_enable_condition_select.sv ***
// Purpose: Self-checking bench for the condition selector
// Assumes: Host model drives the pins; travel limits on inputs 5 and 6
// Notes: Normally closed limits, so pins 5 and 6 idle ON
`timescale 1ns/1ps
module test_function_enable_condition_select;
  logic i_clk, i_reset_n, i_ce, i_wr, i_rd, i_motor_stopped, slow;
  logic i_low_speed, i_speed_attain, i_speed_match, i_zero_speed, i_near;
  logic i_in_position, i_pos_cmd_zero, i_torque_limited, i_velocity_limited;
  logic [7:0] i_addr, want, i_generic_in, o_func_valid;
  logic [31:0] i_wdata, o_rdata, d;
  logic [8:0] st; // Packed status levels
  logic signed [15:0] i_velocity_monitor;
  logic o_cw_travel_limit, o_ccw_travel_limit, o_cmd_inhibit, o_servo_brake;
  logic o_cw_vel_limit_zero, o_ccw_vel_limit_zero, o_dyn_brake, o_coast;
  logic o_servo_enable, sb, db, co, sv, ih, e;
  logic [15:0] o_torque_limit;
  int fail_count, check_count, cyc;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40,
    8'h5C, 8'h3C, 8'h18};
  logic [31:0] rv [10] = '{32'h0D, 32'h0B, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h40};
  // Patterns chosen so each condition is seen both ways
  logic [7:0] pg [3] = '{8'hA5, 8'h5A, 8'hFF};
  logic [8:0] ps [3] = '{9'h155, 9'h0AA, 9'h1FF};
  logic signed [15:0] pv [3] = '{16'sd101, -16'sd101, -16'sd100};
  assign {i_velocity_limited, i_torque_limited, i_pos_cmd_zero, i_in_position,
    i_near, i_zero_speed, i_speed_match, i_speed_attain, i_low_speed} = st;
  fec_condition_select #(.VW(16), .TW(16)) fec_condition_select_inst (
    .i_clk, .i_reset_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_generic_in, .i_low_speed, .i_speed_attain, .i_speed_match,
    .i_zero_speed, .i_near, .i_in_position, .i_pos_cmd_zero,
    .i_torque_limited, .i_velocity_limited, .i_velocity_monitor,
    .i_motor_stopped, .o_func_valid, .o_cw_travel_limit, .o_ccw_travel_limit,
    .o_cmd_inhibit, .o_cw_vel_limit_zero, .o_ccw_vel_limit_zero,
    .o_servo_brake, .o_dyn_brake, .o_coast, .o_servo_enable, .o_torque_limit
  );
  fec_host_model fec_host_model_inst (
    .i_clk, .i_want(want), .i_slow(slow), .o_generic_in(i_generic_in)
  );
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Hang guard, well above the expected run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp_word(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  // Settle then sample mid-cycle, away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  // Reference: bit 0 of a code inverts, unlisted codes stay off
  function automatic logic exp_valid(input logic [5:0] c, input logic [7:0] g,
      input logic [8:0] s, input logic signed [15:0] v);
    logic k;
    case (c[5:1])
      5'h09: k = s[0];
      5'h0A: k = s[1];
      5'h0B: k = s[2];
      5'h0C: k = s[3];
      5'h0D: k = s[5];
      5'h0E: k = s[7];
      5'h0F: k = s[8];
      5'h10: k = s[4];
      5'h11: k = v > 16'sd100;
      5'h12: k = v < -16'sd100;
      5'h13: k = s[6] & s[5];
      default: k = (c[5:1] inside {[5'h01:5'h08]}) ?
        g[3'(c[5:1] - 5'h01)] : 1'b0;
    endcase
    return (c > 6'h27) ? 1'b0 : k ^ c[0];
  endfunction
  initial begin
    {i_reset_n, i_wr, i_rd, i_motor_stopped, slow, i_ce} = 6'b000001;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    want = 8'h30;
    st = 9'h000;
    i_velocity_monitor = 16'sd0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      rd(ra[k], d);
      cmp_word("reset_reg", rv[k], d);
    end
    wr(8'h5C, 32'hFFFF_FFC1);
    rd(8'h5C, d);
    cmp_word("func7_code", 32'h01, d);
    $display("test registers done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h64);
    for (int c = 0; c < 43; c++) begin
      wr(8'h40, (c == 42) ? 32'h3F : 32'(c));
      for (int p = 0; p < 3; p++) begin
        @(posedge i_clk);
        want <= pg[p];
        st <= ps[p];
        i_velocity_monitor <= pv[p];
        settle(5);
        e = exp_valid((c == 42) ? 6'h3F : 6'(c), pg[p], ps[p], pv[p]);
        cmp_bit("func_valid0", e, o_func_valid[0]);
      end
    end
    $display("test selection codes done");
    wr(8'h00, 32'h0D);
    wr(8'h04, 32'h0B);
    wr(8'h10, 32'h200);
    wr(8'h40, 32'h00);
    for (int a = 0; a < 8; a++) begin
      wr(8'h08, 32'(a));
      wr(8'h0C, (a == 3) ? 32'h300 : 32'h100);
      slow <= a[1];
      i_motor_stopped <= 1'b0;
      want <= a[0] ? 8'h20 : 8'h10;
      for (int t = 0; t < 20 && !(o_cw_travel_limit | o_ccw_travel_limit); t++)
        @(posedge i_clk);
      settle(3);
      {sb, db, co} = {a == 0 || a == 3 || a == 7, a == 1 || a == 4,
        a == 2 || a == 5};
      sv = a == 0 || a == 3 || a == 6 || a == 7;
      ih = a != 6;
      cmp_bit("cw_zero", !a[0], o_cw_vel_limit_zero);
      cmp_bit("ccw_zero", a[0], o_ccw_vel_limit_zero);
      cmp_bit("cw_trip", !a[0], o_cw_travel_limit);
      cmp_bit("ccw_trip", a[0], o_ccw_travel_limit);
      cmp_word("torque", (a == 0 || a == 7) ? 32'h100 : 32'h200,
        {16'h0, o_torque_limit});
      rd(8'h18, d);
      cmp_word("stop_status", {16'h0, 8'h80, 1'b0, sv, co, db, sb, ih, a[0],
        !a[0]}, d);
      @(posedge i_clk);
      i_motor_stopped <= 1'b1;
      settle(3);
      sv = a <= 2 || a >= 6;
      rd(8'h18, d);
      cmp_word("hold_status", {16'h0, 8'h80, 1'b0, sv, 3'h0, ih, a[0],
        !a[0]}, d);
      @(posedge i_clk);
      want <= 8'h30;
      settle(12);
      rd(8'h18, d);
      cmp_word("clear_status", 32'h8040, d);
    end
    $display("test travel actions done");
    // Enable low freezes the pin path, so the trip waits
    @(posedge i_clk);
    i_ce <= 1'b0;
    want <= 8'h10;
    settle(8);
    cmp_bit("ce_freeze", 1'b0, o_cw_travel_limit);
    @(posedge i_clk);
    i_ce <= 1'b1;
    settle(8);
    cmp_bit("ce_resume", 1'b1, o_cw_travel_limit);
    $display("test clock enable done");
    end_of_test();
  end
endmodule
